// >>> tb/tb_top.sv
// Purpose: self-checking bench for the converter result/compare register block
// Assumes: AXI4-Lite master driven by the bench, non-blocking updates after rising edges
// Notes: random stimulus from a fixed-seed lfsr, corner cases mixed in
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk_sys_i = 1'b0, reset_n_i = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, sampling_o, sign_select_o, irq_o;
   logic [1:0] bresp, rresp, resolution_o;
   logic [31:0] rdata;
   logic [11:0] calibration_o, res_in = 12'h000;
   logic conv_done = 1'b0, diff = 1'b0, smp_start = 1'b0, ack = 1'b0;
   int error_cnt = 0, num_checks = 0;
   logic [31:0] lfsr_st = 32'hec74;
   initial begin
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   arc_regs i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_done_i(conv_done),
      .conversion_result_i(res_in), .diff_mode_i(diff), .sample_start_i(smp_start), .irq_ack_i(ack),
      .sampling_o(sampling_o), .calibration_o(calibration_o), .sign_select_o(sign_select_o),
      .resolution_o(resolution_o), .irq_o(irq_o));
   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   function automatic logic [31:0] rnd();
      lfsr_st = {lfsr_st[30:0], lfsr_st[31] ^ lfsr_st[21] ^ lfsr_st[1] ^ lfsr_st[0]};
      return lfsr_st;
   endfunction
   // reserved code 01 is read as twelve-bit right adjusted
   function automatic logic [15:0] fmt(logic [11:0] r, logic [1:0] m, logic sgn, logic dif);
      if (m == 2'b11) begin
         return {r, 4'h0};
      end else if (m == 2'b10) begin
         return {(sgn ? {8{r[7]}} : 8'h00), r[7:0]};
      end
      return {(dif ? {4{r[11]}} : 4'h0), r};
   endfunction
   function automatic logic hit(logic [15:0] w, logic [15:0] c, logic sgn, logic above);
      if (sgn) begin
         return above ? ($signed(w) > $signed(c)) : ($signed(w) < $signed(c));
      end
      return above ? (w > c) : (w < c);
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tmo();
      error_cnt++;
      $display("CHECK FAILED bus handshake expected answer seen timeout");
      complete_run();
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge clk_sys_i);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (!(awready && wready) && n < 100);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      while (!bvalid && n < 200) begin
         @(posedge clk_sys_i);
         n++;
      end
      if (n >= 200) tmo();
      chk("bresp", {14'h0, bresp}, {14'h0, er});
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] idx, output logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge clk_sys_i);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (!arready && n < 100);
      arvalid <= 1'b0;
      while (!rvalid && n < 200) begin
         @(posedge clk_sys_i);
         n++;
      end
      if (n >= 200) tmo();
      chk("rresp", {14'h0, rresp}, {14'h0, er});
      chk("rdata upper", rdata[31:16], 16'h0);
      d = rdata[7:0];
      rready <= 1'b0;
   endtask
   task automatic conv(input logic [11:0] r);
      @(posedge clk_sys_i);
      conv_done <= 1'b1;
      res_in <= r;
      @(posedge clk_sys_i);
      conv_done <= 1'b0;
      res_in <= ~r;
      @(posedge clk_sys_i);
   endtask
   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      logic [7:0] v, h, ctl;
      logic [5:0] idxs[11];
      logic [15:0] w, c;
      logic [11:0] r;
      int cnt;
      idxs = '{arc_pkg::IDX_FLAG, arc_pkg::IDX_HOLD, arc_pkg::IDX_SAMP, arc_pkg::IDX_CALL, arc_pkg::IDX_CALH,
         arc_pkg::IDX_COMPARE_LOW_REG, arc_pkg::IDX_COMPARE_HIGH_REG, arc_pkg::IDX_CTRL, arc_pkg::IDX_MASK, arc_pkg::IDX_RESL,
         arc_pkg::IDX_RESH};
      repeat (10) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      foreach (idxs[i]) begin
         rd(idxs[i], v, arc_pkg::RESP_OKAY);
         chk("reset value", {8'h0, v}, 16'h0);
      end
      chk("sign select", {15'h0, sign_select_o}, 16'h0);
      chk("irq", {15'h0, irq_o}, 16'h0);
      $display("test reset done");
      wr(arc_pkg::IDX_HOLD, 8'ha5, arc_pkg::RESP_OKAY);
      rd(arc_pkg::IDX_HOLD, v, arc_pkg::RESP_OKAY);
      chk("hold", {8'h0, v}, 16'h00a5);
      wr(6'h3f, 8'h3c, arc_pkg::RESP_SLVERR);
      rd(6'h3f, v, arc_pkg::RESP_SLVERR);
      chk("unmapped", {8'h0, v}, 16'h0);
      wr(arc_pkg::IDX_RESL, 8'hff, arc_pkg::RESP_OKAY);
      rd(arc_pkg::IDX_RESL, v, arc_pkg::RESP_OKAY);
      chk("result write ignored", {8'h0, v}, 16'h0);
      r = 12'(rnd());
      wr(arc_pkg::IDX_CALL, r[7:0], arc_pkg::RESP_OKAY);
      wr(arc_pkg::IDX_CALH, {4'h0, r[11:8]}, arc_pkg::RESP_OKAY);
      chk("calibration", {4'h0, calibration_o}, {4'h0, r});
      $display("test storage done");
      for (int i = 0; i < 12; i++) begin
         ctl = 8'(rnd());
         ctl[0] = 1'b0;
         ctl[2:1] = i[1:0];
         diff <= ctl[7];
         wr(arc_pkg::IDX_CTRL, ctl, arc_pkg::RESP_OKAY);
         chk("resolution", {14'h0, resolution_o}, {14'h0, ctl[2:1]});
         chk("sign select", {15'h0, sign_select_o}, {15'h0, ctl[4]});
         r = (i < 4) ? {i[0], 11'h080} : 12'(rnd());
         conv(r);
         w = fmt(r, ctl[2:1], ctl[4], ctl[7]);
         rd(arc_pkg::IDX_FLAG, v, arc_pkg::RESP_OKAY);
         chk("flag set", {8'h0, v}, 16'h0001);
         rd(arc_pkg::IDX_RESL, v, arc_pkg::RESP_OKAY);
         chk("result low", {8'h0, v}, {8'h0, w[7:0]});
         rd(arc_pkg::IDX_HOLD, h, arc_pkg::RESP_OKAY);
         chk("captured high", {8'h0, h}, {8'h0, w[15:8]});
         rd(arc_pkg::IDX_RESH, v, arc_pkg::RESP_OKAY);
         chk("result high", {8'h0, v}, {8'h0, w[15:8]});
         wr(arc_pkg::IDX_FLAG, 8'h01, arc_pkg::RESP_OKAY);
      end
      $display("test formats done");
      wr(arc_pkg::IDX_MASK, 8'h01, arc_pkg::RESP_OKAY);
      conv(12'h123);
      chk("irq raised", {15'h0, irq_o}, 16'h1);
      wr(arc_pkg::IDX_FLAG, 8'h00, arc_pkg::RESP_OKAY);
      chk("flag kept on zero", {15'h0, irq_o}, 16'h1);
      wr(arc_pkg::IDX_FLAG, 8'h01, arc_pkg::RESP_OKAY);
      chk("flag cleared by one", {15'h0, irq_o}, 16'h0);
      conv(12'h456);
      @(posedge clk_sys_i);
      ack <= 1'b1;
      @(posedge clk_sys_i);
      ack <= 1'b0;
      @(posedge clk_sys_i);
      @(posedge clk_sys_i);
      chk("flag cleared by vector", {15'h0, irq_o}, 16'h0);
      wr(arc_pkg::IDX_MASK, 8'h00, arc_pkg::RESP_OKAY);
      conv(12'h789);
      chk("irq masked", {15'h0, irq_o}, 16'h0);
      rd(arc_pkg::IDX_FLAG, v, arc_pkg::RESP_OKAY);
      chk("flag under mask", {8'h0, v}, 16'h0001);
      wr(arc_pkg::IDX_FLAG, 8'h01, arc_pkg::RESP_OKAY);
      $display("test interrupt done");
      for (int i = 0; i < 16; i++) begin
         // first pass: minus one against zero must hit only as a signed compare
         ctl = (i == 0) ? 8'h11 : {3'h0, 5'(rnd())} | 8'h01;
         if (ctl[2:1] == 2'b01) ctl[2:1] = 2'b00;
         diff <= (i == 0) ? 1'b1 : ctl[4];
         c = (i == 0) ? 16'h0 : 16'(rnd());
         r = (i == 0) ? 12'hfff : 12'(rnd());
         wr(arc_pkg::IDX_COMPARE_LOW_REG, c[7:0], arc_pkg::RESP_OKAY);
         wr(arc_pkg::IDX_COMPARE_HIGH_REG, c[15:8], arc_pkg::RESP_OKAY);
         wr(arc_pkg::IDX_CTRL, ctl, arc_pkg::RESP_OKAY);
         conv(r);
         w = fmt(r, ctl[2:1], ctl[4], (i == 0) ? 1'b1 : ctl[4]);
         rd(arc_pkg::IDX_FLAG, v, arc_pkg::RESP_OKAY);
         chk("compare flag", {8'h0, v}, {15'h0, hit(w, c, ctl[4], ctl[3])});
         wr(arc_pkg::IDX_FLAG, 8'h01, arc_pkg::RESP_OKAY);
      end
      rd(arc_pkg::IDX_COMPARE_LOW_REG, v, arc_pkg::RESP_OKAY);
      chk("compare low", {8'h0, v}, {8'h0, c[7:0]});
      wr(arc_pkg::IDX_COMPARE_HIGH_REG, ~c[15:8], arc_pkg::RESP_OKAY);
      rd(arc_pkg::IDX_COMPARE_HIGH_REG, v, arc_pkg::RESP_OKAY);
      chk("held high byte", {8'h0, v}, {8'h0, c[15:8]});
      $display("test compare done");
      for (int i = 0; i < 3; i++) begin
         ctl = {i == 2 ? 3'h2 : 3'h0, 5'h00};
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'h3f : 8'h03;
         wr(arc_pkg::IDX_CTRL, ctl, arc_pkg::RESP_OKAY);
         wr(arc_pkg::IDX_SAMP, v, arc_pkg::RESP_OKAY);
         @(posedge clk_sys_i);
         smp_start <= 1'b1;
         @(posedge clk_sys_i);
         smp_start <= 1'b0;
         cnt = 0;
         for (int n = 0; n < 2000; n++) begin
            @(posedge clk_sys_i);
            if (sampling_o === 1'b1) cnt++;
            else break;
         end
         chk("sample length", cnt[15:0], 16'((v + 1) * (4 << ctl[7:5]) / 2));
      end
      $display("test sampling done");
      complete_run();
   end
   initial begin
      repeat (90000) @(posedge clk_sys_i);
      tmo();
   end
endmodule
`default_nettype wire

// >>> verilog/arc_pkg.sv
// Purpose: shared constants for the converter result/compare register block
// Assumes: byte-wide registers on 32-bit words, byte address = index * 4
// Notes: indices with no printed offset are placed in the 0x0d and 0x20 ranges
`default_nettype none
package arc_pkg;
   // -------------------------------------------------------------
   // register indices (byte address is index * 4)
   // -------------------------------------------------------------
   localparam logic [5:0] IDX_FLAG = 6'h06;
   localparam logic [5:0] IDX_HOLD = 6'h07;
   localparam logic [5:0] IDX_SAMP = 6'h08;
   localparam logic [5:0] IDX_CALL = 6'h0c;
   localparam logic [5:0] IDX_CALH = 6'h0d;
   localparam logic [5:0] IDX_COMPARE_LOW_REG = 6'h18;
   localparam logic [5:0] IDX_COMPARE_HIGH_REG = 6'h19;
   localparam logic [5:0] IDX_CTRL = 6'h20;
   localparam logic [5:0] IDX_MASK = 6'h21;
   localparam logic [5:0] IDX_RESL = 6'h24;
   localparam logic [5:0] IDX_RESH = 6'h25;
   localparam int ADDR_W = 8;
   localparam int IDX_LSB = 2;
   // -------------------------------------------------------------
   // fields and reset values
   // -------------------------------------------------------------
   localparam int FLAG_BIT = 0;
   localparam int SAMP_W = 6;
   localparam int CALH_W = 4;
   localparam int CTRL_CMPEN_BIT = 0;
   localparam int CTRL_RES_LSB = 1;
   localparam int CTRL_ABOVE_BIT = 3;
   localparam int CTRL_SIGN_BIT = 4;
   localparam int CTRL_PSC_LSB = 5;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // half converter-clock period at the smallest division of four
   localparam logic [15:0] HALF_BASE = 16'h0002;
   typedef enum logic [1:0] {
      RES_12R = 2'b00,
      RES_RSV = 2'b01,
      RES_8R = 2'b10,
      RES_12L = 2'b11
   } arc_res_e;
   typedef enum logic {
      SMP_IDLE = 1'b0,
      SMP_RUN = 1'b1
   } arc_smp_e;
endpackage
`default_nettype wire

// >>> verilog/arc_regs.sv
// Purpose: result, compare, calibration and flag registers of a converter channel
// Assumes: converter signals are on clk_sys_i; AXI4-Lite register access
// Notes: all registers are one byte in the low lane of a 32-bit word
//
// Summary of operation
// - conversion end sets channel flag bit 0
// - compare mode sets flag only on hit
// - interrupt vector execution clears the flag
// - writing one clears flag, zero keeps
// - low-byte read captures high byte into hold
// - hold register is ordinary read/write storage
// - sampling lasts length plus one half periods
// - twelve-bit calibration pair, low byte stores lsbs
// - left-adjusted twelve-bit placement, low nibble zero
// - right-adjusted twelve-bit, sign extend when differential
// - eight-bit result, high byte sign or zero
// - sixteen-bit compare value, signed in signed mode
// - format codes: 00, 10, 11; 01 reserved
// - sign select resets unsigned, set means signed
// - converter clock divides by four to 512
`timescale 1ns/1ns
`default_nettype none
module arc_regs (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic conv_done_i,
   input wire logic [11:0] conversion_result_i,
   input wire logic diff_mode_i,
   input wire logic sample_start_i,
   input wire logic irq_ack_i,
   output logic sampling_o,
   output logic [11:0] calibration_o,
   output logic sign_select_o,
   output logic [1:0] resolution_o,
   output logic irq_o
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic known_idx(input logic [5:0] idx);
      case (idx)
         arc_pkg::IDX_FLAG, arc_pkg::IDX_HOLD, arc_pkg::IDX_SAMP, arc_pkg::IDX_CALL,
         arc_pkg::IDX_CALH, arc_pkg::IDX_COMPARE_LOW_REG, arc_pkg::IDX_COMPARE_HIGH_REG, arc_pkg::IDX_CTRL,
         arc_pkg::IDX_MASK, arc_pkg::IDX_RESL, arc_pkg::IDX_RESH: known_idx = 1'b1;
         default: known_idx = 1'b0;
      endcase
   endfunction

   // place a raw result into the 16-bit result word
   function automatic logic [15:0] fmt_word(input logic [11:0] res, input logic [1:0] mode,
                                            input logic sgn, input logic diff);
      logic ext12;
      logic ext8;
      ext12 = diff & res[11];
      ext8 = sgn & res[7];
      case (mode)
         arc_pkg::RES_12L: fmt_word = {res, 4'h0};
         arc_pkg::RES_8R: fmt_word = {{8{ext8}}, res[7:0]};
         default: fmt_word = {{4{ext12}}, res};
      endcase
   endfunction

   logic [7:0] samp_r;
   logic [7:0] cal_low_r;
   logic [3:0] cal_high_r;
   logic [7:0] cmp_low_r;
   logic [7:0] cmp_high_r;
   logic [7:0] ctrl_r;
   logic [15:0] result_r;
   logic [7:0] hold_r;
   logic hold_pend_r;
   logic flag_r;
   logic mask_r;
   logic [1:0] bresp_r;
   logic bvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic rvalid_r;

   // ----------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------
   // address and data are taken together, so either arrival order works
   logic wr_go;
   logic rd_go;
   logic [5:0] wr_idx;
   logic [5:0] rd_idx;
   logic wr_lane;
   logic [7:0] wr_byte;
   assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
   assign rd_go = s_axi_arvalid & ~rvalid_r;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign wr_idx = s_axi_awaddr[arc_pkg::ADDR_W-1:arc_pkg::IDX_LSB];
   assign rd_idx = s_axi_araddr[arc_pkg::ADDR_W-1:arc_pkg::IDX_LSB];
   assign wr_lane = wr_go & s_axi_wstrb[0];
   assign wr_byte = s_axi_wdata[7:0];

   function automatic logic wr_hit(input logic lane, input logic [5:0] idx, input logic [5:0] reg_idx);
      wr_hit = lane & (idx == reg_idx);
   endfunction
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         bvalid_r <= 1'b0;
         bresp_r <= arc_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= known_idx(wr_idx) ? arc_pkg::RESP_OKAY : arc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   // reserved bits are dropped on write so they always read zero
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         samp_r <= arc_pkg::REG_RESET;
         cal_low_r <= arc_pkg::REG_RESET;
         cal_high_r <= arc_pkg::REG_RESET[3:0];
         cmp_low_r <= arc_pkg::REG_RESET;
         cmp_high_r <= arc_pkg::REG_RESET;
         ctrl_r <= arc_pkg::REG_RESET;
         mask_r <= 1'b0;
      end else begin
         if (wr_hit(wr_lane, wr_idx, arc_pkg::IDX_SAMP)) begin
            samp_r <= {2'h0, wr_byte[arc_pkg::SAMP_W-1:0]};
         end
         if (wr_hit(wr_lane, wr_idx, arc_pkg::IDX_CALL)) begin
            cal_low_r <= wr_byte;
         end
         if (wr_hit(wr_lane, wr_idx, arc_pkg::IDX_CALH)) begin
            cal_high_r <= wr_byte[arc_pkg::CALH_W-1:0];
         end
         if (wr_hit(wr_lane, wr_idx, arc_pkg::IDX_COMPARE_LOW_REG)) begin
            cmp_low_r <= wr_byte;
         end
         if (wr_hit(wr_lane, wr_idx, arc_pkg::IDX_COMPARE_HIGH_REG)) begin
            cmp_high_r <= wr_byte;
         end
         if (wr_hit(wr_lane, wr_idx, arc_pkg::IDX_CTRL)) begin
            ctrl_r <= wr_byte;
         end
         if (wr_hit(wr_lane, wr_idx, arc_pkg::IDX_MASK)) begin
            mask_r <= wr_byte[arc_pkg::FLAG_BIT];
         end
      end
   end

   logic sign_sel;
   logic cmp_en;
   logic cmp_above;
   logic [1:0] res_mode;
   logic [2:0] psc;
   assign sign_sel = ctrl_r[arc_pkg::CTRL_SIGN_BIT];
   assign cmp_en = ctrl_r[arc_pkg::CTRL_CMPEN_BIT];
   assign cmp_above = ctrl_r[arc_pkg::CTRL_ABOVE_BIT];
   assign res_mode = ctrl_r[arc_pkg::CTRL_RES_LSB+1:arc_pkg::CTRL_RES_LSB];
   assign psc = ctrl_r[arc_pkg::CTRL_PSC_LSB+2:arc_pkg::CTRL_PSC_LSB];
   assign calibration_o = {cal_high_r, cal_low_r};
   assign sign_select_o = sign_sel;
   assign resolution_o = res_mode;
   // ----------------------------------------------------------------
   // result capture and compare
   // ----------------------------------------------------------------
   logic [15:0] new_word;
   logic [15:0] cmp_word;
   logic cmp_gt;
   logic cmp_lt;
   logic cmp_hit;
   assign new_word = fmt_word(conversion_result_i, res_mode, sign_sel, diff_mode_i);
   assign cmp_word = {cmp_high_r, cmp_low_r};
   // signed mode treats both words as two's complement
   assign cmp_gt = sign_sel ? ($signed(new_word) > $signed(cmp_word)) : (new_word > cmp_word);
   assign cmp_lt = sign_sel ? ($signed(new_word) < $signed(cmp_word)) : (new_word < cmp_word);
   assign cmp_hit = cmp_above ? cmp_gt : cmp_lt;

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         result_r <= {arc_pkg::REG_RESET, arc_pkg::REG_RESET};
      end else if (conv_done_i) begin
         result_r <= new_word;
      end
   end

   // ----------------------------------------------------------------
   // completion flag and interrupt
   // ----------------------------------------------------------------
   logic flag_set;
   logic flag_clr;
   assign flag_set = conv_done_i & (~cmp_en | cmp_hit);
   assign flag_clr = irq_ack_i | (wr_hit(wr_lane, wr_idx, arc_pkg::IDX_FLAG) & wr_byte[arc_pkg::FLAG_BIT]);

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         flag_r <= 1'b0;
      end else begin
         // a new event in the clearing cycle is kept
         flag_r <= flag_set | (flag_r & ~flag_clr);
      end
   end
   assign irq_o = flag_r & mask_r;
   // ----------------------------------------------------------------
   // read path and byte holding register
   // ----------------------------------------------------------------
   logic low_read;
   logic high_read;
   logic [7:0] live_high;
   logic [7:0] rd_byte;
   assign low_read = rd_go & ((rd_idx == arc_pkg::IDX_RESL) | (rd_idx == arc_pkg::IDX_CALL) |
                              (rd_idx == arc_pkg::IDX_COMPARE_LOW_REG));
   assign high_read = rd_go & ((rd_idx == arc_pkg::IDX_RESH) | (rd_idx == arc_pkg::IDX_CALH) |
                               (rd_idx == arc_pkg::IDX_COMPARE_HIGH_REG));
   always_comb begin
      case (rd_idx)
         arc_pkg::IDX_RESL: live_high = result_r[15:8];
         arc_pkg::IDX_CALL: live_high = {4'h0, cal_high_r};
         default: live_high = cmp_high_r;
      endcase
   end

   always_comb begin
      case (rd_idx)
         arc_pkg::IDX_FLAG: rd_byte = {7'h00, flag_r};
         arc_pkg::IDX_HOLD: rd_byte = hold_r;
         arc_pkg::IDX_SAMP: rd_byte = samp_r;
         arc_pkg::IDX_CALL: rd_byte = cal_low_r;
         arc_pkg::IDX_CALH: rd_byte = hold_pend_r ? hold_r : {4'h0, cal_high_r};
         arc_pkg::IDX_COMPARE_LOW_REG: rd_byte = cmp_low_r;
         arc_pkg::IDX_COMPARE_HIGH_REG: rd_byte = hold_pend_r ? hold_r : cmp_high_r;
         arc_pkg::IDX_CTRL: rd_byte = ctrl_r;
         arc_pkg::IDX_MASK: rd_byte = {7'h00, mask_r};
         arc_pkg::IDX_RESL: rd_byte = result_r[7:0];
         arc_pkg::IDX_RESH: rd_byte = hold_pend_r ? hold_r : result_r[15:8];
         default: rd_byte = 8'h00;
      endcase
   end

   // a capture on a low read wins over a software write in the same cycle
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         hold_r <= arc_pkg::REG_RESET;
         hold_pend_r <= 1'b0;
      end else begin
         if (low_read) begin
            hold_r <= live_high;
         end else if (wr_hit(wr_lane, wr_idx, arc_pkg::IDX_HOLD)) begin
            hold_r <= wr_byte;
         end
         if (low_read) begin
            hold_pend_r <= 1'b1;
         end else if (high_read) begin
            hold_pend_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= arc_pkg::RESP_OKAY;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rdata_r <= {24'h00_0000, rd_byte};
         rresp_r <= known_idx(rd_idx) ? arc_pkg::RESP_OKAY : arc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   // ----------------------------------------------------------------
   // sampling phase timer
   // ----------------------------------------------------------------
   // half period is 2 << psc peripheral clocks, so 4..512 division
   arc_pkg::arc_smp_e smp_state_r;
   logic [15:0] smp_cnt_r;
   logic [15:0] smp_len;
   assign smp_len = 16'((32'(samp_r[arc_pkg::SAMP_W-1:0]) + 32'd1) * 32'(arc_pkg::HALF_BASE << psc));

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         smp_state_r <= arc_pkg::SMP_IDLE;
         smp_cnt_r <= 16'h0000;
      end else begin
         unique case (smp_state_r)
            arc_pkg::SMP_IDLE: begin
               if (sample_start_i) begin
                  smp_state_r <= arc_pkg::SMP_RUN;
                  smp_cnt_r <= smp_len - 16'h0001;
               end
            end
            arc_pkg::SMP_RUN: begin
               if (smp_cnt_r == 16'h0000) begin
                  smp_state_r <= arc_pkg::SMP_IDLE;
               end else begin
                  smp_cnt_r <= smp_cnt_r - 16'h0001;
               end
            end
         endcase
      end
   end
   assign sampling_o = (smp_state_r == arc_pkg::SMP_RUN);
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   sequence seq_sample_begin;
      !sampling_o && sample_start_i && samp_r == 8'h00 && psc == 3'h0;
   endsequence
   sequence seq_sample_short;
      sampling_o [*2] ##1 !sampling_o;
   endsequence
   AST_DONE_SETS: assert property (conv_done_i && !cmp_en |=> flag_r)
      else $error("flag not set after conversion end");
   AST_CMP_MISS: assert property (conv_done_i && cmp_en && !cmp_hit && !flag_r |=> !flag_r)
      else $error("flag set without compare hit");
   AST_ACK_CLEARS: assert property (irq_ack_i && !conv_done_i |=> !flag_r)
      else $error("vector execution did not clear flag");
   AST_W1C: assert property (wr_go && s_axi_wstrb[0] && wr_idx == arc_pkg::IDX_FLAG && !s_axi_wdata[0]
                             && flag_r && !irq_ack_i |=> flag_r)
      else $error("writing zero changed the flag");
   AST_HOLD_CAPTURE: assert property (low_read && rd_idx == arc_pkg::IDX_RESL |=> hold_r == $past(result_r[15:8]))
      else $error("high byte not captured");
   AST_HIGH_FROM_HOLD: assert property (high_read && hold_pend_r |=> s_axi_rdata[7:0] == $past(hold_r))
      else $error("high read did not return held byte");
   AST_SAMPLE_LEN: assert property (seq_sample_begin |=> seq_sample_short)
      else $error("sampling phase length wrong");
   AST_LEFT_FMT: assert property (conv_done_i && res_mode == arc_pkg::RES_12L |=> result_r[3:0] == 4'h0 &&
                                  result_r[15:4] == $past(conversion_result_i))
      else $error("left adjusted placement wrong");
   AST_EIGHT_FMT: assert property (conv_done_i && res_mode == arc_pkg::RES_8R && !sign_sel |=> result_r[15:8] == 8'h00)
      else $error("unsigned eight-bit high byte not zero");
   AST_IRQ: assert property (conv_done_i && !cmp_en && mask_r && !wr_go |=> irq_o)
      else $error("interrupt not raised after conversion end");
endmodule
`default_nettype wire
